// file: src/grar_reg_bank.sv
// Generic register bank with access-type bits and a set/drop alias pair
`timescale 1ns/1ns
`include "grar_defines.svh"
module grar_reg_bank
	import grar_pkg::*;
(
	// Clock and resets
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire logic                    soft_rst,
	// Primary access port, read and write
	input  wire logic                    wr0_en,
	input  wire logic                    rd0_en,
	input  wire logic [`GRAR_ADDR_W-1:0] addr0,
	input  wire logic [`GRAR_DATA_W-1:0] wdata0,
	// Secondary write port
	input  wire logic                    wr1_en,
	input  wire logic [`GRAR_ADDR_W-1:0] addr1,
	input  wire logic [`GRAR_DATA_W-1:0] wdata1,
	// Read answer
	output logic      [`GRAR_DATA_W-1:0] rd_data,
	output logic                         rd_valid,
	// Hardware state shown in the read-only register
	input  wire logic [`GRAR_DATA_W-1:0] hw_status,
	// Register contents driving the rest of the peripheral
	output logic      [`GRAR_DATA_W-1:0] ctrl_value,
	output logic      [`GRAR_DATA_W-1:0] dbg_value,
	output logic      [`GRAR_DATA_W-1:0] alias_value,
	output logic      [`GRAR_DATA_W-1:0] cmd_value,
	output logic                         cmd_pulse
);

	// Address decode, used by both ports
	function automatic grar_sel_t grar_decode(input logic [`GRAR_ADDR_W-1:0] a);
		grar_sel_t s;
		s = GRAR_SEL_NONE;
		if (a == `GRAR_OFS_CTRL) begin
			s = GRAR_SEL_CTRL;
		end else if (a == `GRAR_OFS_STATUS) begin
			s = GRAR_SEL_STATUS;
		end else if (a == `GRAR_OFS_CMD) begin
			s = GRAR_SEL_CMD;
		end else if (a == `GRAR_OFS_DBG) begin
			s = GRAR_SEL_DBG;
		end else if (a == `GRAR_OFS_DROP) begin
			s = GRAR_SEL_DROP;
		end else if (a == `GRAR_OFS_SET) begin
			s = GRAR_SEL_SET;
		end
		return s;
	endfunction

	grar_sel_t                   sel0;
	grar_sel_t                   sel1;
	logic                        ctrl_hit0;
	logic                        ctrl_hit1;
	logic                        dbg_hit0;
	logic                        dbg_hit1;
	logic                        cmd_hit0;
	logic                        cmd_hit1;
	logic [`GRAR_DATA_W-1:0]     set_bits;
	logic [`GRAR_DATA_W-1:0]     drop_bits;
	logic [`GRAR_DATA_W-1:0]     next_ctrl;
	logic [`GRAR_DATA_W-1:0]     next_dbg;
	logic [`GRAR_DATA_W-1:0]     next_cmd;
	logic                        next_cmd_pulse;
	logic [`GRAR_DATA_W-1:0]     shared_bits;
	logic [`GRAR_DATA_W-1:0]     rd_word;

	// Decode of both ports
	assign sel0      = grar_decode(addr0);
	assign sel1      = grar_decode(addr1);
	assign ctrl_hit0 = wr0_en && (sel0 == GRAR_SEL_CTRL);
	assign ctrl_hit1 = wr1_en && (sel1 == GRAR_SEL_CTRL);
	assign dbg_hit0  = wr0_en && (sel0 == GRAR_SEL_DBG);
	assign dbg_hit1  = wr1_en && (sel1 == GRAR_SEL_DBG);
	assign cmd_hit0  = wr0_en && (sel0 == GRAR_SEL_CMD);
	assign cmd_hit1  = wr1_en && (sel1 == GRAR_SEL_CMD);

	assign set_bits  = ((wr0_en && sel0 == GRAR_SEL_SET) ? wdata0 : '0)
		| ((wr1_en && sel1 == GRAR_SEL_SET) ? wdata1 : '0);
	assign drop_bits = ((wr0_en && sel0 == GRAR_SEL_DROP) ? wdata0 : '0)
		| ((wr1_en && sel1 == GRAR_SEL_DROP) ? wdata1 : '0);

	// Read/write storage, primary port wins on a clash
	assign next_ctrl = ctrl_hit0 ? (wdata0 & `GRAR_MASK_CTRL)
		: ctrl_hit1 ? (wdata1 & `GRAR_MASK_CTRL) : ctrl_value;
	assign next_dbg  = dbg_hit0 ? (wdata0 & `GRAR_MASK_DBG)
		: dbg_hit1 ? (wdata1 & `GRAR_MASK_DBG) : dbg_value;

	// Write-only command, one pulse per write
	assign next_cmd       = cmd_hit0 ? (wdata0 & `GRAR_MASK_CMD)
		: cmd_hit1 ? (wdata1 & `GRAR_MASK_CMD) : cmd_value;
	assign next_cmd_pulse = cmd_hit0 || cmd_hit1;

	// Shared bits behind the alias pair
	grar_alias_reg #(
		.WIDTH     (`GRAR_DATA_W),
		.RST_VALUE (`GRAR_RST_ALIAS)
	) u_alias (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.soft_rst  (soft_rst),
		.set_bits  (set_bits & `GRAR_MASK_ALIAS),
		.drop_bits (drop_bits & `GRAR_MASK_ALIAS),
		.value     (shared_bits)
	);

	// Shared bits shown to the peripheral, straight from the alias flops
	assign alias_value = shared_bits;

	// Read selection; unmapped and write-only read zero
	// Status shows live hardware state
	// Both aliases read the same bits
	assign rd_word =
		(sel0 == GRAR_SEL_CTRL)   ? ctrl_value :
		(sel0 == GRAR_SEL_STATUS) ? (hw_status & `GRAR_MASK_STATUS) :
		(sel0 == GRAR_SEL_DBG)    ? dbg_value :
		(sel0 == GRAR_SEL_DROP)   ? (shared_bits & `GRAR_MASK_ALIAS) :
		(sel0 == GRAR_SEL_SET)    ? (shared_bits & `GRAR_MASK_ALIAS) : '0;

	// Control and command registers, soft reset restores
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_value <= `GRAR_RST_CTRL;
			cmd_value  <= `GRAR_RST_CMD;
			cmd_pulse  <= 1'b0;
		end else if (soft_rst) begin
			ctrl_value <= `GRAR_RST_CTRL;
			cmd_value  <= `GRAR_RST_CMD;
			cmd_pulse  <= 1'b0;
		end else begin
			ctrl_value <= next_ctrl;
			cmd_value  <= next_cmd;
			cmd_pulse  <= next_cmd_pulse;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dbg_value <= `GRAR_RST_DBG;
		end else begin
			dbg_value <= next_dbg;
		end
	end

	// Registered read answer, one cycle after the request
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data  <= '0;
			rd_valid <= 1'b0;
		end else begin
			rd_data  <= rd0_en ? rd_word : '0;
			rd_valid <= rd0_en;
		end
	end

endmodule

// file: src/grar_defines.svh
// Offsets, field masks, reset values and widths of the generic register bank
`ifndef GRAR_DEFINES_SVH
`define GRAR_DEFINES_SVH

// Access port widths
`define GRAR_ADDR_W        8
`define GRAR_DATA_W        32

// Byte offsets of the registers
`define GRAR_OFS_CTRL      8'h00
`define GRAR_OFS_STATUS    8'h04
`define GRAR_OFS_CMD       8'h08
`define GRAR_OFS_DBG       8'h0C
`define GRAR_OFS_DROP      8'h10
`define GRAR_OFS_SET       8'h14

// Implemented bit masks; every other bit is reserved
`define GRAR_MASK_CTRL     32'h0000_00FF
`define GRAR_MASK_STATUS   32'h0000_000F
`define GRAR_MASK_CMD      32'h0000_00FF
`define GRAR_MASK_DBG      32'h0000_0003
`define GRAR_MASK_ALIAS    32'h0000_FFFF

// Reset values
`define GRAR_RST_CTRL      32'h0000_0001
`define GRAR_RST_CMD       32'h0000_0000
`define GRAR_RST_DBG       32'h0000_0000
`define GRAR_RST_ALIAS     32'h0000_0000

`endif

// file: src/grar_pkg.sv
// Types shared by the generic register bank
package grar_pkg;

	// Register selected by an access address
	typedef enum logic [2:0] {
		GRAR_SEL_NONE   = 3'b000,
		GRAR_SEL_CTRL   = 3'b001,
		GRAR_SEL_STATUS = 3'b010,
		GRAR_SEL_CMD    = 3'b011,
		GRAR_SEL_DBG    = 3'b100,
		GRAR_SEL_DROP   = 3'b101,
		GRAR_SEL_SET    = 3'b110
	} grar_sel_t;

endpackage

// file: src/grar_alias_reg.sv
// Shared register behind a set alias and a drop alias
`timescale 1ns/1ns
module grar_alias_reg #(
	parameter int          WIDTH     = 32,
	parameter logic [31:0] RST_VALUE = 32'h0000_0000
) (
	// Clock and resets
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             soft_rst,
	// Bit masks already gated by their write strobes
	input  wire logic [WIDTH-1:0] set_bits,
	input  wire logic [WIDTH-1:0] drop_bits,
	// Shared underlying bits
	output logic      [WIDTH-1:0] value
);

	logic [WIDTH-1:0] next_value;

	assign next_value = (value | set_bits) & ~drop_bits;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			value <= RST_VALUE[WIDTH-1:0];
		end else if (soft_rst) begin
			value <= RST_VALUE[WIDTH-1:0];
		end else begin
			value <= next_value;
		end
	end

endmodule

// file: verification/grar_reg_bank_asserts.sv
// Port checker of the generic register bank
`timescale 1ns/1ns
`include "grar_defines.svh"
module grar_reg_bank_asserts (
	// Clock and resets
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        soft_rst,
	// Access ports
	input wire logic        wr0_en,
	input wire logic        rd0_en,
	input wire logic [7:0]  addr0,
	input wire logic [31:0] wdata0,
	input wire logic        wr1_en,
	input wire logic [7:0]  addr1,
	input wire logic [31:0] wdata1,
	// Observed results
	input wire logic [31:0] rd_data,
	input wire logic        rd_valid,
	input wire logic [31:0] hw_status,
	input wire logic [31:0] ctrl_value,
	input wire logic [31:0] dbg_value,
	input wire logic        cmd_pulse
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Alias write and read steps
	sequence set_ones;
		wr0_en && addr0 == `GRAR_OFS_SET && wdata0 == 32'h0000_FFFF && !wr1_en && !soft_rst;
	endsequence
	sequence both_wr;
		wr0_en && addr0 == `GRAR_OFS_SET && wr1_en && addr1 == `GRAR_OFS_DROP
			&& wdata1 == 32'h0000_FFFF && !soft_rst;
	endsequence
	sequence drop_rd;
		rd0_en && addr0 == `GRAR_OFS_DROP;
	endsequence
	rd_answer_a: assert property (rd0_en |=> rd_valid)
		else $error("read not answered");
	ctrl_read_a: assert property (rd0_en && addr0 == `GRAR_OFS_CTRL |=> rd_data == $past(ctrl_value))
		else $error("control read wrong");
	ctrl_write_a: assert property (wr0_en && addr0 == `GRAR_OFS_CTRL && !soft_rst
		|=> ctrl_value == ($past(wdata0) & `GRAR_MASK_CTRL))
		else $error("control write wrong");
	soft_keep_a: assert property (soft_rst && !wr0_en && !wr1_en
		|=> ctrl_value == `GRAR_RST_CTRL && !cmd_pulse && $stable(dbg_value))
		else $error("soft reset wrong");
	cmd_pulse_a: assert property (wr0_en && addr0 == `GRAR_OFS_CMD && !soft_rst |=> cmd_pulse)
		else $error("command pulse missing");
	status_read_a: assert property (rd0_en && addr0 == `GRAR_OFS_STATUS
		|=> rd_data == ($past(hw_status) & `GRAR_MASK_STATUS))
		else $error("status read wrong");
	set_read_a: assert property (set_ones ##1 drop_rd |=> rd_data == 32'h0000_FFFF)
		else $error("alias read wrong");
	drop_wins_a: assert property (both_wr ##1 drop_rd |=> rd_data == 32'h0000_0000)
		else $error("drop did not win");
endmodule
bind grar_reg_bank grar_reg_bank_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.soft_rst(soft_rst), .wr0_en(wr0_en), .rd0_en(rd0_en), .addr0(addr0), .wdata0(wdata0),
	.wr1_en(wr1_en), .addr1(addr1), .wdata1(wdata1), .rd_data(rd_data), .rd_valid(rd_valid),
	.hw_status(hw_status), .ctrl_value(ctrl_value), .dbg_value(dbg_value),
	.cmd_pulse(cmd_pulse));

// file: verification/grar_reg_bank_tb.sv
// Self-checking bench of the generic register bank
`timescale 1ns/1ns
`include "grar_defines.svh"
module grar_reg_bank_tb;
	logic        ref_clk = 0, rst_n = 0, soft_rst = 0, wr0_en = 0, rd0_en = 0, wr1_en = 0;
	logic [7:0]  addr0 = 8'h00, addr1 = 8'h00;
	logic [31:0] wdata0 = 32'h0, wdata1 = 32'h0, hw_status = 32'h0, d, q[$];
	logic [31:0] rd_data, ctrl_value, dbg_value, alias_value, cmd_value;
	logic        rd_valid, cmd_pulse;
	int          n_errors = 0, comparisons = 0;
	// Clock source
	initial forever #25 ref_clk = ~ref_clk;
	grar_reg_bank dut (.ref_clk(ref_clk), .rst_n(rst_n), .soft_rst(soft_rst), .wr0_en(wr0_en),
		.rd0_en(rd0_en), .addr0(addr0), .wdata0(wdata0), .wr1_en(wr1_en), .addr1(addr1),
		.wdata1(wdata1), .rd_data(rd_data), .rd_valid(rd_valid), .hw_status(hw_status),
		.ctrl_value(ctrl_value), .dbg_value(dbg_value), .alias_value(alias_value),
		.cmd_value(cmd_value), .cmd_pulse(cmd_pulse));
	// Compare of register outputs
	task check_val(input string n, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Compare of read answers
	task check_rd(input logic [31:0] e);
		check_val("rd_data", e, rd_data);
	endtask
	// One port 0 cycle; a read notes its answer
	task op(input logic w, r, input logic [7:0] a, input logic [31:0] v, e);
		@(negedge ref_clk);
		wr0_en = w;
		rd0_en = r;
		addr0 = a;
		wdata0 = v;
		wr1_en = 0;
		soft_rst = 0;
		if (r) q.push_back(e);
	endtask
	task stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Answer watcher takes the oldest note
	always @(negedge ref_clk) if (rd_valid === 1'b1) check_rd(q.pop_front());
	// Watchdog, far beyond the some forty cycles of the tests
	initial begin
		repeat (3000) @(posedge ref_clk);
		n_errors++;
		stop_test;
	end
	initial begin
		void'($urandom(96));
		hw_status = $urandom;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk) rst_n = 1;
		check_val("ctrl_value", `GRAR_RST_CTRL, ctrl_value);
		check_val("dbg_value", `GRAR_RST_DBG, dbg_value);
		op(0, 1, `GRAR_OFS_CTRL, 0, `GRAR_RST_CTRL);
		op(0, 1, `GRAR_OFS_SET, 0, `GRAR_RST_ALIAS);
		$display("reset test done");
		repeat (4) begin
			d = $urandom;
			op(1, 0, `GRAR_OFS_CTRL, d, 0);
			op(0, 1, `GRAR_OFS_CTRL, 0, d & `GRAR_MASK_CTRL);
			op(1, 0, `GRAR_OFS_DBG, d, 0);
			op(0, 1, `GRAR_OFS_DBG, 0, d & `GRAR_MASK_DBG);
		end
		hw_status = $urandom;
		op(1, 0, `GRAR_OFS_STATUS, d, 0);
		op(0, 1, `GRAR_OFS_STATUS, 0, hw_status & `GRAR_MASK_STATUS);
		op(0, 1, 8'h40, 0, 0);
		op(1, 0, `GRAR_OFS_CMD, 32'h3, 0);
		op(0, 0, 0, 0, 0);
		check_val("cmd_pulse", 1, cmd_pulse);
		check_val("cmd_value", 32'h3, cmd_value);
		$display("access test done");
		op(1, 0, `GRAR_OFS_SET, 32'hFFFF, 0);
		op(1, 1, `GRAR_OFS_DROP, 32'h00F0, 32'hFFFF);
		op(0, 1, `GRAR_OFS_SET, 0, 32'hFF0F);
		check_val("alias_value", 32'hFF0F, alias_value);
		// Set and drop in the same cycle
		@(negedge ref_clk);
		{rd0_en, wr0_en, addr0, wdata0} = {2'b01, `GRAR_OFS_SET, 32'h0F0F};
		{wr1_en, addr1, wdata1} = {1'b1, `GRAR_OFS_DROP, 32'hFFFF};
		op(0, 1, `GRAR_OFS_DROP, 0, 0);
		$display("alias test done");
		op(1, 0, `GRAR_OFS_DBG, 32'h2, 0);
		op(1, 0, `GRAR_OFS_SET, 32'h00FF, 0);
		op(1, 0, `GRAR_OFS_CTRL, 32'h5A, 0);
		@(negedge ref_clk);
		wr0_en = 0;
		soft_rst = 1;
		op(0, 1, `GRAR_OFS_DROP, 0, `GRAR_RST_ALIAS);
		check_val("ctrl_value", `GRAR_RST_CTRL, ctrl_value);
		check_val("dbg_value", 32'h2, dbg_value);
		op(0, 0, 0, 0, 0);
		op(0, 0, 0, 0, 0);
		$display("soft reset test done");
		check_val("pending reads", 0, q.size());
		stop_test;
	end
endmodule
